// ---- common/cfg_decode_regs.svh ----
/*
 * register offsets, field positions and fixed values of the
 * configuration word decoder. Definitions only, included by bare name.
 */
// Functional notes
// - window code picks 25/37.5/50/75 percent window
// - config enable forces watchdog on, unstoppable
// - window-disable bit selects non-window operation
// - postscale ratio is two to the code
// - postscale codes above 10100 act as 10100
// - switch/monitor: 1x none, 01 switch, 00 both
// - bus clock divisor 1, 2, 4, 8
// - clock out only when enabled and osc off/external
// - primary oscillator: off, fast crystal, crystal, external
// - switchover bit enables two-speed start-up
// - secondary oscillator enable bit
// - three-bit start-up oscillator source select
// - pll output divisor 1 to 256
// - pll multiplier 15 to 24
// - pll input divider 1 to 12
// - usb pll bit one disables and bypasses
`ifndef CFG_DECODE_REGS_SVH
`define CFG_DECODE_REGS_SVH

`define CFG_ADDR_W 4
`define CFG_OFS_WORD1 4'h0
`define CFG_OFS_WORD2 4'h4
`define CFG_OFS_STATUS 4'h8
`define CFG_OFS_CTRL 4'hc

`define W1_WINSZ_LSB 24
`define W1_WDT_EN_BIT 23
`define W1_WIN_OFF_BIT 22
`define W1_PS_LSB 16
`define W1_CKSM_LSB 14
`define W1_PBDIV_LSB 12
`define W1_CLK_OUT_BIT 10
`define W1_POSC_LSB 8
`define W1_TWO_SPEED_BIT 7
`define W1_SOSC_BIT 5
`define W1_NOSC_LSB 0
`define W1_RSVD_MASK 32'hfc20_0858

`define W2_ODIV_LSB 16
`define W2_UPLL_BIT 15
`define W2_UIDIV_LSB 8
`define W2_MUL_LSB 4
`define W2_IDIV_LSB 0

`define ST_READY_BIT 0
`define ST_CONFLICT_BIT 1
`define ST_RSVD_BAD_BIT 2
`define ST_WDOG_RUN_BIT 3
`define CTRL_SW_WDOG_BIT 0

`define WDOG_PS_MAX 5'h14
`define LOAD_DELAY 2'h2
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ---- common/cfg_decode_pkg.sv ----
/*
 * types shared by the configuration decoder files.
 * assumes nothing of its surroundings.
 */
package cfg_decode_pkg;
    typedef enum logic [1:0] {
        POSC_EXT_CLOCK,
        POSC_STD_XTAL,
        POSC_HIGH_SPEED_XTAL,
        POSC_OFF
    } osc_mode_t;

    typedef enum logic [2:0] {
        START_FAST_RC,
        START_FAST_RC_DIV_N_PLL,
        START_PRIMARY,
        START_PRIMARY_PLL,
        START_SECONDARY,
        START_LOW_POWER_RC,
        START_FAST_RC_DIV16,
        START_FAST_RC_DIV_N
    } startup_osc_t;

    typedef enum logic {
        LOAD_WAIT,
        LOAD_DONE
    } load_state_t;
endpackage

// ---- src/cfg_word1_decode.sv ----
/*
 * combinational decode of the clock and watchdog configuration word.
 * assumes a stable word; the caller registers the results.
 */
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module cfg_word1_decode (
    // configuration word
    input wire logic [31:0] word,
    // decoded fields
    output logic [2:0] window_eighths,
    output logic [4:0] postscale_log2,
    output logic switch_en,
    output logic monitor_en,
    output logic [1:0] pb_div_log2,
    output logic clk_out_en,
    output cfg_decode_pkg::osc_mode_t osc_mode,
    output cfg_decode_pkg::startup_osc_t startup_sel,
    output logic primary_conflict,
    output logic rsvd_bad
);
    import cfg_decode_pkg::*;
    logic [4:0] ps_code;

    always_comb begin
        unique case (word[`W1_WINSZ_LSB +: 2])
            2'h3: window_eighths = 3'h2;
            2'h2: window_eighths = 3'h3;
            2'h1: window_eighths = 3'h4;
            2'h0: window_eighths = 3'h6;
        endcase
    end

    assign ps_code = word[`W1_PS_LSB +: 5];
    assign postscale_log2 = (ps_code > `WDOG_PS_MAX) ? `WDOG_PS_MAX : ps_code;
    assign switch_en = !word[`W1_CKSM_LSB + 1];
    assign monitor_en = (word[`W1_CKSM_LSB +: 2] == 2'h0);
    assign pb_div_log2 = word[`W1_PBDIV_LSB +: 2];
    assign osc_mode = osc_mode_t'(word[`W1_POSC_LSB +: 2]);
    assign clk_out_en = !word[`W1_CLK_OUT_BIT] && (osc_mode == POSC_OFF || osc_mode == POSC_EXT_CLOCK);
    assign startup_sel = startup_osc_t'(word[`W1_NOSC_LSB +: 3]);
    assign primary_conflict = (startup_sel == START_PRIMARY) && (osc_mode == POSC_OFF);
    assign rsvd_bad = ((word & `W1_RSVD_MASK) != `W1_RSVD_MASK);
endmodule

// ---- src/cfg_word2_decode.sv ----
/*
 * combinational decode of the pll configuration word.
 * assumes a stable word; the caller registers the results.
 */
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module cfg_word2_decode (
    // configuration word
    input wire logic [31:0] word,
    // decoded fields
    output logic [3:0] pll_out_div_log2,
    output logic [4:0] pll_mult,
    output logic [3:0] pll_in_div,
    output logic usb_pll_en,
    output logic [3:0] usb_pll_in_div
);
    function automatic logic [3:0] in_div(input logic [2:0] code);
        unique case (code)
            3'h7: in_div = 4'hc;
            3'h6: in_div = 4'ha;
            default: in_div = 4'(code) + 4'h1;
        endcase
    endfunction

    always_comb begin
        unique case (word[`W2_MUL_LSB +: 3])
            3'h7: pll_mult = 5'h18;
            default: pll_mult = 5'(word[`W2_MUL_LSB +: 3]) + 5'hf;
        endcase
    end

    assign pll_out_div_log2 = (word[`W2_ODIV_LSB +: 3] == 3'h7) ? 4'h8 : 4'(word[`W2_ODIV_LSB +: 3]);
    assign pll_in_div = in_div(word[`W2_IDIV_LSB +: 3]);
    assign usb_pll_en = !word[`W2_UPLL_BIT];
    assign usb_pll_in_div = in_div(word[`W2_UIDIV_LSB +: 3]);
endmodule

// ---- src/clock_watchdog_config_decode.sv ----
/*
 * configuration loader: latches the two nonvolatile configuration words
 * after reset, decodes them into clock and watchdog defaults and
 * exposes them over an AXI4-Lite slave.
 * assumes the nonvolatile words are static pins from another domain.
 */
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module clock_watchdog_config_decode (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // nonvolatile storage
    input wire logic [31:0] nv_clock_watchdog_word,
    input wire logic [31:0] nv_pll_word,
    // axi4-lite write
    input wire logic [`CFG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`CFG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // watchdog defaults
    output logic cfg_ready,
    output logic wdog_run,
    output logic [2:0] wdog_window_size,
    output logic wdog_windowed,
    output logic [4:0] wdog_postscale_sel,
    // clock defaults
    output logic clk_switch_en,
    output logic clk_monitor_en,
    output logic [1:0] periph_bus_div_default,
    output logic clock_output,
    output cfg_decode_pkg::osc_mode_t primary_osc_mode,
    output logic two_speed_startup_en,
    output logic secondary_osc_en,
    output cfg_decode_pkg::startup_osc_t startup_osc_sel,
    // pll defaults
    output logic [3:0] pll_out_div,
    output logic [4:0] pll_multiplier,
    output logic [3:0] pll_in_div,
    output logic usb_pll_en,
    output logic [3:0] usb_pll_in_div
);
    import cfg_decode_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [31:0] nv1_meta_q, nv1_sync_q, nv2_meta_q, nv2_sync_q;
    logic [31:0] word1_q, word2_q;
    load_state_t load_q;
    logic [1:0] load_cnt_q;
    logic ready_q;
    logic sw_wdog_en_q;
    logic [2:0] win_d;
    logic [4:0] ps_d;
    logic sw_d, mon_d, clk_out_d, conflict_d, rsvd_bad_d;
    logic [1:0] pbdiv_d;
    osc_mode_t posc_d;
    startup_osc_t nosc_d;
    logic [3:0] odiv_d, idiv_d, uidiv_d;
    logic [4:0] mul_d;
    logic upll_d;
    logic aw_have_q, w_have_q;
    logic [`CFG_ADDR_W-1:0] waddr_q, raddr;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic [31:0] status_word;

    // two flops ahead of any logic reading the storage pins
    always_ff @(posedge aclk) begin
        nv1_meta_q <= nv_clock_watchdog_word;
        nv1_sync_q <= nv1_meta_q;
        nv2_meta_q <= nv_pll_word;
        nv2_sync_q <= nv2_meta_q;
    end

    // wait for the synchronisers to settle, then latch once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_q <= LOAD_WAIT;
            load_cnt_q <= 2'h0;
            word1_q <= 32'h0;
            word2_q <= 32'h0;
        end else begin
            unique case (load_q)
                LOAD_WAIT: begin
                    if (load_cnt_q == `LOAD_DELAY) begin
                        word1_q <= nv1_sync_q;
                        word2_q <= nv2_sync_q;
                        load_q <= LOAD_DONE;
                    end else begin
                        load_cnt_q <= load_cnt_q + 2'h1;
                    end
                end
                LOAD_DONE: begin
                    load_q <= LOAD_DONE;
                end
            endcase
        end
    end

    cfg_word1_decode u_word1 (
        .word(word1_q),
        .window_eighths(win_d),
        .postscale_log2(ps_d),
        .switch_en(sw_d),
        .monitor_en(mon_d),
        .pb_div_log2(pbdiv_d),
        .clk_out_en(clk_out_d),
        .osc_mode(posc_d),
        .startup_sel(nosc_d),
        .primary_conflict(conflict_d),
        .rsvd_bad(rsvd_bad_d)
    );

    cfg_word2_decode u_word2 (
        .word(word2_q),
        .pll_out_div_log2(odiv_d),
        .pll_mult(mul_d),
        .pll_in_div(idiv_d),
        .usb_pll_en(upll_d),
        .usb_pll_in_div(uidiv_d)
    );

    // decoded defaults, held at safe values until the words are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_q <= 1'b0;
            wdog_window_size <= 3'h0;
            wdog_windowed <= 1'b0;
            wdog_postscale_sel <= 5'h0;
            clk_switch_en <= 1'b0;
            clk_monitor_en <= 1'b0;
            periph_bus_div_default <= 2'h0;
            clock_output <= 1'b0;
            primary_osc_mode <= POSC_OFF;
            two_speed_startup_en <= 1'b0;
            secondary_osc_en <= 1'b0;
            startup_osc_sel <= START_FAST_RC;
            pll_out_div <= 4'h0;
            pll_multiplier <= 5'h0;
            pll_in_div <= 4'h0;
            usb_pll_en <= 1'b0;
            usb_pll_in_div <= 4'h0;
        end else if (load_q == LOAD_DONE) begin
            ready_q <= 1'b1;
            wdog_window_size <= win_d;
            wdog_windowed <= !word1_q[`W1_WIN_OFF_BIT];
            wdog_postscale_sel <= ps_d;
            clk_switch_en <= sw_d;
            clk_monitor_en <= mon_d;
            periph_bus_div_default <= pbdiv_d;
            clock_output <= clk_out_d;
            primary_osc_mode <= posc_d;
            two_speed_startup_en <= word1_q[`W1_TWO_SPEED_BIT];
            secondary_osc_en <= word1_q[`W1_SOSC_BIT];
            startup_osc_sel <= nosc_d;
            pll_out_div <= odiv_d;
            pll_multiplier <= mul_d;
            pll_in_div <= idiv_d;
            usb_pll_en <= upll_d;
            usb_pll_in_div <= uidiv_d;
        end
    end

    assign cfg_ready = ready_q;

    // software may start the watchdog but never stop a forced one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdog_run <= 1'b0;
        end else begin
            wdog_run <= ready_q && (word1_q[`W1_WDT_EN_BIT] || sw_wdog_en_q);
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                unique case (waddr_q)
                    `CFG_OFS_WORD1, `CFG_OFS_WORD2, `CFG_OFS_STATUS, `CFG_OFS_CTRL: s_axi_bresp <= `AXI_OKAY;
                    default: s_axi_bresp <= `AXI_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control register; configuration words stay read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_wdog_en_q <= 1'b0;
        end else if (aw_have_q && w_have_q && !s_axi_bvalid && waddr_q == `CFG_OFS_CTRL && wstrb0_q) begin
            sw_wdog_en_q <= wdata_q[`CTRL_SW_WDOG_BIT];
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`ST_READY_BIT] = ready_q;
        status_word[`ST_CONFLICT_BIT] = ready_q && conflict_d;
        status_word[`ST_RSVD_BAD_BIT] = ready_q && rsvd_bad_d;
        status_word[`ST_WDOG_RUN_BIT] = wdog_run;
    end

    assign raddr = s_axi_araddr;

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            unique case (raddr)
                `CFG_OFS_WORD1: s_axi_rdata <= word1_q;
                `CFG_OFS_WORD2: s_axi_rdata <= word2_q;
                `CFG_OFS_STATUS: s_axi_rdata <= status_word;
                `CFG_OFS_CTRL: s_axi_rdata <= {31'h0, sw_wdog_en_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    property p_window;
        ready_q |-> (wdog_window_size == ((word1_q[`W1_WINSZ_LSB +: 2] == 2'h3) ? 3'h2 :
            (word1_q[`W1_WINSZ_LSB +: 2] == 2'h2) ? 3'h3 :
            (word1_q[`W1_WINSZ_LSB +: 2] == 2'h1) ? 3'h4 : 3'h6));
    endproperty
    a_window: assert property (p_window) else $error("window size mismatch");

    property p_forced_run;
        ready_q && word1_q[`W1_WDT_EN_BIT] |=> wdog_run [*3];
    endproperty
    a_forced_run: assert property (p_forced_run) else $error("forced watchdog not running");

    property p_no_stop;
        $fell(wdog_run) |-> !word1_q[`W1_WDT_EN_BIT];
    endproperty
    a_no_stop: assert property (p_no_stop) else $error("forced watchdog stopped");

    property p_windowed;
        ready_q |-> wdog_windowed != word1_q[`W1_WIN_OFF_BIT];
    endproperty
    a_windowed: assert property (p_windowed) else $error("window mode mismatch");

    property p_postscale;
        ready_q |-> wdog_postscale_sel == ((word1_q[`W1_PS_LSB +: 5] > `WDOG_PS_MAX) ?
            `WDOG_PS_MAX : word1_q[`W1_PS_LSB +: 5]);
    endproperty
    a_postscale: assert property (p_postscale) else $error("postscale mismatch");

    property p_switch;
        ready_q |-> (clk_switch_en == !word1_q[`W1_CKSM_LSB + 1]) && (clk_monitor_en -> clk_switch_en);
    endproperty
    a_switch: assert property (p_switch) else $error("clock switch mismatch");

    property p_pbdiv;
        ready_q |-> periph_bus_div_default == word1_q[`W1_PBDIV_LSB +: 2];
    endproperty
    a_pbdiv: assert property (p_pbdiv) else $error("bus divisor mismatch");

    property p_clkout;
        clock_output |-> !word1_q[`W1_CLK_OUT_BIT] && (primary_osc_mode inside {POSC_OFF, POSC_EXT_CLOCK});
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock output wrongly active");

    property p_load;
        $rose(load_q == LOAD_DONE) |=> ready_q && $stable(word1_q) ##1 $stable(word2_q);
    endproperty
    a_load: assert property (p_load) else $error("load sequence broken");

    property p_hold;
        ready_q |=> ready_q && $stable(word1_q) && $stable(word2_q);
    endproperty
    a_hold: assert property (p_hold) else $error("configuration changed");

    property p_pll;
        ready_q |-> (pll_multiplier inside {[5'hf:5'h15], 5'h18}) && (usb_pll_en != word2_q[`W2_UPLL_BIT]);
    endproperty
    a_pll: assert property (p_pll) else $error("pll setting mismatch");

    property p_outdiv;
        ready_q && word2_q[`W2_ODIV_LSB +: 3] == 3'h7 |-> pll_out_div == 4'h8;
    endproperty
    a_outdiv: assert property (p_outdiv) else $error("pll output divisor mismatch");

    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule

// ---- dv/clock_watchdog_config_decode_tb.sv ----
/*
 * self-checking bench for the configuration word decoder.
 * assumes the design files and the shared header and package are compiled first.
 */
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module clock_watchdog_config_decode_tb;
    import cfg_decode_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] nv_a = 32'h0;
    logic [31:0] nv_b = 32'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cfg_ready, wdog_run, wdog_windowed;
    logic [1:0] bresp, rresp, pb_div;
    logic [31:0] rdata, rd_v;
    logic [1:0] rsp;
    logic [2:0] win;
    logic [4:0] ps_sel, pll_mul;
    logic sw_en, mon_en, clk_out, two_sp, sosc, usb_en;
    osc_mode_t posc;
    startup_osc_t nosc;
    logic [3:0] odiv, idiv, uidiv;
    int failures = 0;
    int tests_run = 0;
    localparam logic [3:0] DIVS [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

    clock_watchdog_config_decode dut_u (.aclk(aclk), .aresetn(aresetn), .nv_clock_watchdog_word(nv_a),
        .nv_pll_word(nv_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg_ready(cfg_ready), .wdog_run(wdog_run),
        .wdog_window_size(win), .wdog_windowed(wdog_windowed), .wdog_postscale_sel(ps_sel),
        .clk_switch_en(sw_en), .clk_monitor_en(mon_en), .periph_bus_div_default(pb_div),
        .clock_output(clk_out), .primary_osc_mode(posc), .two_speed_startup_en(two_sp),
        .secondary_osc_en(sosc), .startup_osc_sel(nosc), .pll_out_div(odiv), .pll_multiplier(pll_mul),
        .pll_in_div(idiv), .usb_pll_en(usb_en), .usb_pll_in_div(uidiv));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic stop_test();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [4:0] ps_of(input logic [2:0] c);
        ps_of = (c < 3'h6) ? {c, 2'b00} : ((c == 3'h6) ? 5'h15 : 5'h1f);
    endfunction

    function automatic logic [31:0] w1(input logic [2:0] c);
        logic [1:0] p;
        p = c[1:0] ^ 2'h1;
        w1 = `W1_RSVD_MASK | {6'h00, c[1:0], c[0], c[1], 1'b0, ps_of(c), c[1:0], c[1:0], 1'b0, c[2], p,
            c[0], 1'b0, c[1], 2'b00, c};
        if (c == 3'h5) begin
            w1[21] = 1'b0;
        end
    endfunction

    function automatic logic [31:0] w2(input logic [2:0] c);
        w2 = 32'hfff8_7888 | {13'h0000, c, c[0], 4'h0, ~c, 1'b0, c, 1'b0, c};
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic load(input logic [2:0] c);
        int n;
        aresetn <= 1'b0;
        nv_a <= w1(c);
        nv_b <= w2(c);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (n = 0; n < 20 && cfg_ready !== 1'b1; n++) @(posedge aclk);
        repeat (2) @(posedge aclk);
        chk(cfg_ready, 1);
    endtask

    task automatic check_cfg(input logic [2:0] c);
        logic [1:0] p;
        p = c[1:0] ^ 2'h1;
        chk(win, (c[1:0] == 2'h3) ? 2 : (c[1:0] == 2'h2) ? 3 : (c[1:0] == 2'h1) ? 4 : 6);
        chk(wdog_run, c[0]);
        chk(wdog_windowed, !c[1]);
        chk(ps_sel, (ps_of(c) > 5'h14) ? 5'h14 : ps_of(c));
        chk({sw_en, mon_en}, {~c[1], c[1:0] == 2'h0});
        chk(pb_div, c[1:0]);
        chk(clk_out, !c[2] && (p == 2'h3 || p == 2'h0));
        chk(posc, p);
        chk(two_sp, c[0]);
        chk(sosc, c[1]);
        chk(nosc, c);
        chk(odiv, (c == 3'h7) ? 8 : c);
        chk(pll_mul, (c == 3'h7) ? 24 : 15 + c);
        chk(idiv, DIVS[c]);
        chk({usb_en, uidiv}, {~c[0], DIVS[~c]});
    endtask

    task automatic sw_enable_test();
        axi_wr(4'hc, 32'h1, rsp);
        chk(rsp, `AXI_OKAY);
        repeat (3) @(posedge aclk);
        chk(wdog_run, 1);
    endtask

    task automatic forced_and_bus_test();
        axi_wr(4'hc, 32'h0, rsp);
        repeat (3) @(posedge aclk);
        chk(wdog_run, 1);
        axi_wr(4'h0, 32'h0, rsp);
        chk(rsp, `AXI_OKAY);
        axi_rd(4'h0, rd_v, rsp);
        chk(rd_v, w1(3'h7));
        axi_rd(4'h1, rd_v, rsp);
        chk(rsp, `AXI_SLVERR);
        chk(rd_v, 32'h0);
        axi_wr(4'h1, 32'h1, rsp);
        chk(rsp, `AXI_SLVERR);
    endtask

    task automatic decode_test(input logic [2:0] c);
        load(c);
        check_cfg(c);
        axi_rd(4'h0, rd_v, rsp);
        chk(rd_v, w1(c));
        chk(rsp, `AXI_OKAY);
        axi_rd(4'h4, rd_v, rsp);
        chk(rd_v, w2(c));
        axi_rd(4'h8, rd_v, rsp);
        chk(rd_v, {28'h0, c[0], c == 3'h5, c == 3'h2, 1'b1});
        nv_a <= ~w1(c);
        nv_b <= ~w2(c);
        repeat (6) @(posedge aclk);
        check_cfg(c);
    endtask

    initial begin
        #200us;
        failures++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge aclk);
        chk({cfg_ready, wdog_run, posc, awready, arready}, 6'b00_1111);
        for (int i = 0; i < 8; i++) begin
            decode_test(i[2:0]);
            if (i == 6) sw_enable_test();
            if (i == 7) forced_and_bus_test();
        end
        stop_test();
    end
endmodule
